// ===== ssc_exec_top.sv
/*
  Execution block for subtract with borrow, force carry, arithmetic shift
  right and group pointer load, with flag register and an APB register port.
  Assumes the decoder resolves indirect operands and supplies their values,
  and that the register file takes one write per done pulse.
*/
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module ssc_exec_top (
  input wire logic sys_clk,                 // Core clock, 50 MHz
  input wire logic rst_n,                   // Synchronous reset, active low
  input wire logic req_valid,               // Decoder offers an instruction
  output logic req_ready,                   // Block takes it this cycle
  input wire ssc_pkg::ssc_req_t req,        // Opcode, dst field and operands
  output ssc_pkg::ssc_wr_t wr,              // Result write to register file
  output logic done,                        // Instruction finished
  output logic [7:0] flags,                 // Current flag register
  output logic [7:0] grp_ptr,               // Current working group pointer
  input wire logic [11:0] paddr,            // APB address
  input wire logic psel,                    // APB select
  input wire logic penable,                 // APB enable
  input wire logic pwrite,                  // APB direction
  input wire logic [31:0] pwdata,           // APB write data
  output logic [31:0] prdata,               // APB read data
  output logic pready,                      // APB ready
  output logic pslverr                      // APB error
);

  ssc_pkg::ssc_state_t state_ff;
  ssc_pkg::ssc_req_t req_ff;
  ssc_pkg::ssc_wr_t wr_ff;
  ssc_pkg::ssc_alu_op_t alu_mode;
  logic [7:0] flags_ff;
  logic [7:0] ptr_ff;
  logic [7:0] waddr_ff;
  logic [7:0] last_op_ff;
  logic [7:0] done_cnt_ff;
  logic [7:0] alu_res;
  logic [7:0] alu_flags;
  logic [7:0] nxt_waddr;
  logic [3:0] cyc_len;
  logic [31:0] rd_mux;
  logic [31:0] prdata_ff;
  logic en_ff;
  logic bad_ff;
  logic done_ff;
  logic pslverr_ff;
  logic accept;
  logic t_busy;
  logic t_expire;
  logic op_known;
  logic is_sbc;
  logic is_asr;
  logic apb_setup;
  logic apb_wr;
  logic addr_hit;

  // Opcode classes of the captured instruction
  function automatic logic sbc_op(input logic [7:0] op);
    sbc_op = (op == ssc_pkg::OP_SBC_RR) || (op == ssc_pkg::OP_SBC_RIR) ||
             (op == ssc_pkg::OP_SBC_FR) || (op == ssc_pkg::OP_SBC_FIR) ||
             (op == ssc_pkg::OP_SBC_FIM) || (op == ssc_pkg::OP_SBC_IRIM);
  endfunction

  function automatic logic asr_op(input logic [7:0] op);
    asr_op = (op == ssc_pkg::OP_ASR_R) || (op == ssc_pkg::OP_ASR_IR);
  endfunction

  // Instruction handshake
  assign accept = req_valid && req_ready;
  assign req_ready = (state_ff == ssc_pkg::EXE_IDLE) && en_ff;
  assign op_known = sbc_op(req.opcode) || asr_op(req.opcode) ||
                    (req.opcode == ssc_pkg::OP_FORCE_C) || (req.opcode == ssc_pkg::OP_LD_PTR);

  // Execution length per opcode
  always_comb begin
    cyc_len = ssc_pkg::CYC_BAD;
    if ((req.opcode == ssc_pkg::OP_SBC_RR) || (req.opcode == ssc_pkg::OP_SBC_RIR)) begin
      cyc_len = ssc_pkg::CYC_SHORT;
    end else if (sbc_op(req.opcode)) begin
      cyc_len = ssc_pkg::CYC_LONG;
    end else if (req.opcode == ssc_pkg::OP_FORCE_C) begin
      cyc_len = ssc_pkg::CYC_SHORT;
    end else if (asr_op(req.opcode)) begin
      cyc_len = ssc_pkg::CYC_SHORT;
    end else if (req.opcode == ssc_pkg::OP_LD_PTR) begin
      cyc_len = ssc_pkg::CYC_SHORT;
    end
  end

  // Destination address, working-register fields folded into the group
  always_comb begin
    nxt_waddr = req.dst_field;
    if ((req.opcode == ssc_pkg::OP_SBC_RR) || (req.opcode == ssc_pkg::OP_SBC_RIR)) begin
      nxt_waddr = {ptr_ff[7:4], req.dst_field[3:0]};
    end else if ((req.opcode == ssc_pkg::OP_SBC_FR) || (req.opcode == ssc_pkg::OP_SBC_FIR) ||
                 (req.opcode == ssc_pkg::OP_SBC_FIM) || (req.opcode == ssc_pkg::OP_ASR_R)) begin
      if (req.dst_field[7:4] == ssc_pkg::WREG_NIBBLE) begin
        nxt_waddr = {ptr_ff[7:4], req.dst_field[3:0]};
      end
    end
  end

  ssc_cycle_timer u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(accept),
    .load_val(cyc_len - 4'h1),
    .busy(t_busy),
    .expire(t_expire)
  );

  // Run state follows the timer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff <= ssc_pkg::EXE_IDLE;
    end else if (accept) begin
      state_ff <= ssc_pkg::EXE_RUN;
    end else if (t_expire) begin
      state_ff <= ssc_pkg::EXE_IDLE;
    end
  end

  // Capture operands and target at acceptance
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      req_ff <= '0;
      waddr_ff <= 8'h00;
    end else if (accept) begin
      req_ff <= req;
      waddr_ff <= nxt_waddr;
    end
  end

  assign is_sbc = sbc_op(req_ff.opcode);
  assign is_asr = asr_op(req_ff.opcode);

  always_comb begin
    alu_mode = ssc_pkg::ALU_PASS;
    if (is_sbc) begin
      alu_mode = ssc_pkg::ALU_SBC;
    end else if (is_asr) begin
      alu_mode = ssc_pkg::ALU_ASR;
    end
  end

  ssc_alu u_alu (
    .mode(alu_mode),
    .a_in(req_ff.dst_val),
    .b_in(req_ff.src_val),
    .flags_in(flags_ff),
    .res_out(alu_res),
    .flags_out(alu_flags)
  );

  // Write back only the destination, on the last cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ff <= '0;
    end else if (t_expire && (is_sbc || is_asr)) begin
      wr_ff.en <= 1'b1;
      wr_ff.addr <= waddr_ff;
      wr_ff.data <= alu_res;
    end else begin
      wr_ff.en <= 1'b0;
    end
  end

  // Done pulse and completion counter
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
      done_cnt_ff <= 8'h00;
      last_op_ff <= 8'h00;
    end else begin
      done_ff <= t_expire;
      if (t_expire) begin
        done_cnt_ff <= done_cnt_ff + 8'h01;
        last_op_ff <= req_ff.opcode;
      end
    end
  end

  // Flags: instruction update wins over a software write
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flags_ff <= ssc_pkg::RST_FLAGS;
    end else if (t_expire && (is_sbc || is_asr)) begin
      flags_ff <= alu_flags;
    end else if (t_expire && (req_ff.opcode == ssc_pkg::OP_FORCE_C)) begin
      flags_ff[ssc_pkg::FLG_C] <= 1'b1;
    end else if (apb_wr && (paddr == ssc_pkg::ADDR_FLAGS)) begin
      flags_ff <= pwdata[7:0];
    end
  end

  // Group pointer: instruction load wins over a software write
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ptr_ff <= ssc_pkg::RST_PTR;
    end else if (t_expire && (req_ff.opcode == ssc_pkg::OP_LD_PTR)) begin
      ptr_ff <= {req_ff.src_val[7:4], 4'h0};
    end else if (apb_wr && (paddr == ssc_pkg::ADDR_GRP_PTR)) begin
      ptr_ff <= {pwdata[7:4], 4'h0};
    end
  end

  // Control enable and sticky bad-opcode flag; a new set beats a clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      en_ff <= ssc_pkg::RST_EN;
      bad_ff <= 1'b0;
    end else begin
      if (apb_wr && (paddr == ssc_pkg::ADDR_CTRL)) begin
        en_ff <= pwdata[ssc_pkg::CTRL_EN];
      end
      if (accept && !op_known) begin
        bad_ff <= 1'b1;
      end else if (apb_wr && (paddr == ssc_pkg::ADDR_STATUS) && pwdata[ssc_pkg::STAT_BAD]) begin
        bad_ff <= 1'b0;
      end
    end
  end

  // APB phases; the slave never waits
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign addr_hit = (paddr == ssc_pkg::ADDR_CTRL) || (paddr == ssc_pkg::ADDR_STATUS) ||
                    (paddr == ssc_pkg::ADDR_FLAGS) || (paddr == ssc_pkg::ADDR_GRP_PTR);

  // Read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == ssc_pkg::ADDR_CTRL) begin
      rd_mux[ssc_pkg::CTRL_EN] = en_ff;
    end else if (paddr == ssc_pkg::ADDR_STATUS) begin
      rd_mux[ssc_pkg::STAT_BUSY] = t_busy;
      rd_mux[ssc_pkg::STAT_BAD] = bad_ff;
      rd_mux[ssc_pkg::STAT_OP_LO +: 8] = last_op_ff;
      rd_mux[ssc_pkg::STAT_CNT_LO +: 8] = done_cnt_ff;
    end else if (paddr == ssc_pkg::ADDR_FLAGS) begin
      rd_mux[7:0] = flags_ff;
    end else if (paddr == ssc_pkg::ADDR_GRP_PTR) begin
      rd_mux[7:0] = ptr_ff;
    end
  end

  // Read data and error registered in the setup cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (apb_setup) begin
      prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_ff <= !addr_hit;
    end
  end

  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff && psel && penable;
  assign pready = 1'b1;
  assign wr = wr_ff;
  assign done = done_ff;
  assign flags = flags_ff;
  assign grp_ptr = ptr_ff;

  // Checks of timing and results
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_take_short_sbc;
    accept && ((req.opcode == ssc_pkg::OP_SBC_RR) || (req.opcode == ssc_pkg::OP_SBC_RIR));
  endsequence

  sequence s_take_long_sbc;
    accept && sbc_op(req.opcode) && (req.opcode != ssc_pkg::OP_SBC_RR) &&
      (req.opcode != ssc_pkg::OP_SBC_RIR);
  endsequence

  sequence s_take_force_c;
    accept && (req.opcode == ssc_pkg::OP_FORCE_C);
  endsequence

  a_sbc_short_time: assert property (s_take_short_sbc |=> !done [*5] ##1 done)
    else $error("short subtract did not finish in 6 cycles");

  a_sbc_long_time: assert property (s_take_long_sbc |=> !done [*8] ##1 !done ##1 done)
    else $error("long subtract did not finish in 10 cycles");

  a_sbc_value: assert property (done && is_sbc |-> wr.en && (wr.data ==
      8'(req_ff.dst_val - req_ff.src_val - {7'h00, $past(flags_ff[ssc_pkg::FLG_C])})))
    else $error("subtract result wrong");

  a_dst_only_write: assert property (done && is_sbc |-> wr.addr == waddr_ff)
    else $error("subtract wrote a location other than the destination");

  a_sbc_borrow: assert property (done && is_sbc |-> flags_ff[ssc_pkg::FLG_C] ==
      ({1'b0, req_ff.dst_val} < ({1'b0, req_ff.src_val} +
       {8'h00, $past(flags_ff[ssc_pkg::FLG_C])})))
    else $error("borrow flag wrong");

  a_sbc_zero_sign: assert property (done && is_sbc |->
      (flags_ff[ssc_pkg::FLG_Z] == (wr.data == 8'h00)) &&
      (flags_ff[ssc_pkg::FLG_S] == wr.data[7]))
    else $error("zero or sign flag wrong after subtract");

  a_sbc_overflow: assert property (done && is_sbc |-> flags_ff[ssc_pkg::FLG_V] ==
      ((req_ff.dst_val[7] != req_ff.src_val[7]) && (wr.data[7] == req_ff.src_val[7])))
    else $error("overflow flag wrong after subtract");

  a_sbc_half_dec: assert property (done && is_sbc |-> flags_ff[ssc_pkg::FLG_D] &&
      (flags_ff[ssc_pkg::FLG_H] == ({1'b0, req_ff.dst_val[3:0]} <
       ({1'b0, req_ff.src_val[3:0]} + {4'h0, $past(flags_ff[ssc_pkg::FLG_C])}))))
    else $error("half carry or decimal flag wrong after subtract");

  a_force_c_time: assert property (s_take_force_c |-> ##6 (done && flags_ff[ssc_pkg::FLG_C]))
    else $error("carry not forced high after 6 cycles");

  a_force_c_keep: assert property (done && (req_ff.opcode == ssc_pkg::OP_FORCE_C) |->
      flags_ff[6:0] == $past(flags_ff[6:0]))
    else $error("force carry disturbed other flags");

  a_asr_shape: assert property (accept && asr_op(req.opcode) |-> ##6 (done &&
      wr.data == {req_ff.dst_val[7], req_ff.dst_val[7:1]}))
    else $error("shift result or timing wrong");

  a_asr_flags: assert property (done && is_asr |->
      (flags_ff[ssc_pkg::FLG_C] == req_ff.dst_val[0]) && !flags_ff[ssc_pkg::FLG_V] &&
      (flags_ff[ssc_pkg::FLG_Z] == (wr.data == 8'h00)) &&
      (flags_ff[ssc_pkg::FLG_S] == wr.data[7]) &&
      (flags_ff[3:2] == $past(flags_ff[3:2])))
    else $error("shift flags wrong");

  a_ptr_load: assert property (accept && (req.opcode == ssc_pkg::OP_LD_PTR) |-> ##6
      (done && grp_ptr == {req_ff.src_val[7:4], 4'h0}))
    else $error("group pointer load wrong");

  a_wreg_map: assert property (accept && (req.opcode == ssc_pkg::OP_SBC_FR) &&
      (req.dst_field[7:4] == ssc_pkg::WREG_NIBBLE) |=>
      waddr_ff == {$past(ptr_ff[7:4]), $past(req.dst_field[3:0])})
    else $error("working register field not mapped into group");

endmodule

// ===== ssc_pkg.sv
/*
  Shared constants and types of the execution block: opcodes, cycle counts,
  register indices, flag positions, reset values and carrier structs.
  Assumes a SystemVerilog tool that handles packed structs and enums.
*/
package ssc_pkg;

  // Opcodes handled by this block
  localparam logic [7:0] OP_SBC_RR = 8'h32;    // Working reg, working reg
  localparam logic [7:0] OP_SBC_RIR = 8'h33;   // Working reg, indirect working reg
  localparam logic [7:0] OP_SBC_FR = 8'h34;    // Full reg, full reg
  localparam logic [7:0] OP_SBC_FIR = 8'h35;   // Full reg, indirect full reg
  localparam logic [7:0] OP_SBC_FIM = 8'h36;   // Full reg, immediate
  localparam logic [7:0] OP_SBC_IRIM = 8'h37;  // Indirect full reg, immediate
  localparam logic [7:0] OP_FORCE_C = 8'hdf;   // Force carry high
  localparam logic [7:0] OP_ASR_R = 8'hd0;     // Shift, full reg
  localparam logic [7:0] OP_ASR_IR = 8'hd1;    // Shift, indirect full reg
  localparam logic [7:0] OP_LD_PTR = 8'h31;    // Load group pointer, immediate

  // Execution lengths in core cycles
  localparam logic [3:0] CYC_SHORT = 4'h6;
  localparam logic [3:0] CYC_LONG = 4'ha;
  localparam logic [3:0] CYC_BAD = 4'h2;

  // Upper nibble that marks a working-register operand field
  localparam logic [3:0] WREG_NIBBLE = 4'he;

  // Flag positions in the flag register
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;
  localparam int FLG_D = 3;
  localparam int FLG_H = 2;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h0fa;
  localparam logic [9:0] IDX_STATUS = 10'h0fb;
  localparam logic [9:0] IDX_FLAGS = 10'h0fc;
  localparam logic [9:0] IDX_GRP_PTR = 10'h0fd;
  localparam logic [11:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [11:0] ADDR_FLAGS = {IDX_FLAGS, 2'b00};
  localparam logic [11:0] ADDR_GRP_PTR = {IDX_GRP_PTR, 2'b00};

  // Field positions
  localparam int CTRL_EN = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_BAD = 1;
  localparam int STAT_OP_LO = 8;
  localparam int STAT_CNT_LO = 16;

  // Reset values
  localparam logic [7:0] RST_PTR = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic RST_EN = 1'b1;

  typedef enum logic {EXE_IDLE, EXE_RUN} ssc_state_t;
  typedef enum logic [1:0] {ALU_PASS, ALU_SBC, ALU_ASR} ssc_alu_op_t;

  // Request from the decoder, operands already fetched
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] dst_field;
    logic [7:0] dst_val;
    logic [7:0] src_val;
  } ssc_req_t;

  // Write back to the register file
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } ssc_wr_t;

endpackage

// ===== ssc_alu.sv
/*
  Combinational operand path: subtract with borrow by complement addition,
  arithmetic shift right, or pass-through, with the flag results.
  Assumes operands and carry are stable for the cycle they are read.
*/
`timescale 1ns/1ps
module ssc_alu (
  input wire ssc_pkg::ssc_alu_op_t mode,  // Operation select
  input wire logic [7:0] a_in,            // Destination value
  input wire logic [7:0] b_in,            // Source value
  input wire logic [7:0] flags_in,        // Flags before the operation
  output logic [7:0] res_out,             // Result byte
  output logic [7:0] flags_out            // Flags after the operation
);

  logic [4:0] lo_sum;
  logic [8:0] full_sum;
  logic borrow_in;

  // Complement addition; carry in is the inverted borrow
  assign borrow_in = ~flags_in[ssc_pkg::FLG_C];
  assign lo_sum = {1'b0, a_in[3:0]} + {1'b0, ~b_in[3:0]} + {4'h0, borrow_in};
  assign full_sum = {1'b0, a_in} + {1'b0, ~b_in} + {8'h00, borrow_in};

  // Result and flag selection
  always_comb begin
    res_out = a_in;
    flags_out = flags_in;
    case (mode)
      ssc_pkg::ALU_SBC: begin
        res_out = full_sum[7:0];
        flags_out[ssc_pkg::FLG_C] = ~full_sum[8];
        flags_out[ssc_pkg::FLG_Z] = (full_sum[7:0] == 8'h00);
        flags_out[ssc_pkg::FLG_S] = full_sum[7];
        flags_out[ssc_pkg::FLG_V] = (a_in[7] ^ b_in[7]) & (full_sum[7] == b_in[7]);
        flags_out[ssc_pkg::FLG_H] = ~lo_sum[4];
        flags_out[ssc_pkg::FLG_D] = 1'b1;
      end
      ssc_pkg::ALU_ASR: begin
        res_out = {a_in[7], a_in[7:1]};
        flags_out[ssc_pkg::FLG_C] = a_in[0];
        flags_out[ssc_pkg::FLG_Z] = ({a_in[7], a_in[7:1]} == 8'h00);
        flags_out[ssc_pkg::FLG_S] = a_in[7];
        flags_out[ssc_pkg::FLG_V] = 1'b0;
      end
      default: begin
        res_out = a_in;
        flags_out = flags_in;
      end
    endcase
  end

endmodule

// ===== ssc_cycle_timer.sv
/*
  Down counter that times one instruction; expire marks its last cycle.
  Assumes load is only raised while the counter is idle.
*/
`timescale 1ns/1ps
module ssc_cycle_timer (
  input wire logic sys_clk,         // Core clock
  input wire logic rst_n,           // Synchronous reset, active low
  input wire logic load,            // Start counting
  input wire logic [3:0] load_val,  // Cycles until expire, plus one
  output logic busy,                // Counter running
  output logic expire               // Last counted cycle
);

  logic [3:0] cnt_ff;

  // Count down to zero after a load
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_ff <= 4'h0;
    end else if (load) begin
      cnt_ff <= load_val;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end

  assign busy = (cnt_ff != 4'h0);
  assign expire = (cnt_ff == 4'h1);

endmodule

// ===== ssc_decoder_model.sv
/*
  Decoder and register file model for the execution block: offers one
  request per go pulse, holds it until taken, stores result writes.
  Assumes go is only raised while no request is pending.
*/
`timescale 1ns/1ps
module ssc_decoder_model (
  input wire logic sys_clk,           // Core clock
  input wire logic rst_n,             // Synchronous reset, active low
  input wire logic go,                // Start one request
  input wire ssc_pkg::ssc_req_t nreq, // Request to offer
  input wire logic req_ready,         // Block takes request
  input wire ssc_pkg::ssc_wr_t wr,    // Result write
  output logic req_valid,             // Request offered
  output ssc_pkg::ssc_req_t req       // Offered request
);
  logic [7:0] mem [0:255];
  logic [7:0] last_addr;
  int n_wr;

  // Offer request and hold it; released lines show inverted data
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      req_valid <= 1'b0;
      req <= '0;
    end else if (go && !req_valid) begin
      req_valid <= 1'b1;
      req <= nreq;
    end else if (req_valid && req_ready) begin
      req_valid <= 1'b0;
      req <= ~req;
    end
  end

  // Register file store and write log
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      n_wr <= 0;
    end else if (wr.en) begin
      mem[wr.addr] <= wr.data;
      last_addr <= wr.addr;
      n_wr <= n_wr + 1;
    end
  end
endmodule

// ===== ssc_exec_top_tb_top.sv
/*
  Testbench of the execution block: APB register checks and instruction
  runs with expected results worked out here. Assumes the decoder model.
*/
`timescale 1ns/1ps
module ssc_exec_top_tb_top;
  logic sys_clk, rst_n, go, req_valid, req_ready, done, psel, penable, pwrite, pready, pslverr;
  logic [7:0] flags, grp_ptr, exp_ptr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  ssc_pkg::ssc_req_t nreq, req;
  ssc_pkg::ssc_wr_t wr;
  int n_errors, total_checks;

  ssc_exec_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .wr(wr), .done(done), .flags(flags),
    .grp_ptr(grp_ptr), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ssc_decoder_model mdl (.sys_clk(sys_clk), .rst_n(rst_n), .go(go), .nreq(nreq),
    .req_ready(req_ready), .wr(wr), .req_valid(req_valid), .req(req));

  // Clock, 20 ns period
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 40) begin
      chk("wait_timeout", 32'h0, 32'h1);
      complete_run();
    end
  endtask

  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    tmo(n);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Expected {result, flags}
  function automatic logic [15:0] ref_op(input logic [7:0] op, d, s, f);
    logic [8:0] sum;
    logic [4:0] lo;
    logic [7:0] r;
    sum = {1'b0, d} + {1'b0, ~s} + {8'h00, ~f[7]};
    lo = {1'b0, d[3:0]} + {1'b0, ~s[3:0]} + {4'h0, ~f[7]};
    r = sum[7:0];
    case (op)
      ssc_pkg::OP_FORCE_C: ref_op = {d, f | 8'h80};
      ssc_pkg::OP_LD_PTR, 8'h00: ref_op = {d, f};
      ssc_pkg::OP_ASR_R, ssc_pkg::OP_ASR_IR: begin
        r = {d[7], d[7:1]};
        ref_op = {r, d[0], r == 8'h00, r[7], 1'b0, f[3:0]};
      end
      default: ref_op = {r, ~sum[8], r == 8'h00, r[7],
        (d[7] != s[7]) && (r[7] == s[7]), 1'b1, ~lo[4], f[1:0]};
    endcase
  endfunction

  function automatic logic [7:0] dst_addr(input logic [7:0] op, df);
    if (op inside {ssc_pkg::OP_SBC_RR, ssc_pkg::OP_SBC_RIR} || (df[7:4] == ssc_pkg::WREG_NIBBLE
        && !(op inside {ssc_pkg::OP_SBC_IRIM, ssc_pkg::OP_ASR_IR})))
      return {exp_ptr[7:4], df[3:0]};
    return df;
  endfunction

  // Preset flags, run one instruction, check timing, flags and writes
  task automatic run_op(input logic [7:0] op, df, d, s, f);
    int n;
    int w0;
    logic [15:0] e;
    logic [7:0] a;
    apb(1'b1, ssc_pkg::ADDR_FLAGS, {24'h0, f});
    w0 = mdl.n_wr;
    a = dst_addr(op, df);
    e = ref_op(op, d, s, f);
    @(posedge sys_clk);
    nreq <= '{op, df, d, s};
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!(req_valid === 1'b1 && req_ready === 1'b1) && n < 40);
    tmo(n);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (done !== 1'b1 && n < 40);
    tmo(n);
    chk("cycles", (op inside {[8'h34:8'h37]}) ? 10 : (op == 8'h00) ? 2 : 6, n);
    @(negedge sys_clk);
    chk("flags", {24'h0, e[7:0]}, {24'h0, flags});
    if (op == ssc_pkg::OP_LD_PTR)
      exp_ptr = {s[7:4], 4'h0};
    chk("grp_ptr", {24'h0, exp_ptr}, {24'h0, grp_ptr});
    if (op inside {ssc_pkg::OP_FORCE_C, ssc_pkg::OP_LD_PTR, 8'h00}) begin
      chk("writes", w0, mdl.n_wr);
    end else begin
      chk("writes", w0 + 1, mdl.n_wr);
      chk("waddr", {24'h0, a}, {24'h0, mdl.last_addr});
      chk("result", {24'h0, e[15:8]}, {24'h0, mdl.mem[a]});
    end
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    nreq = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    exp_ptr = 8'h00;
    n_errors = 0;
    total_checks = 0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    apb(1'b0, ssc_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h1, rd);
    apb(1'b0, ssc_pkg::ADDR_FLAGS, 32'h0);
    chk("flags_rst", 32'h0, rd);
    apb(1'b0, ssc_pkg::ADDR_GRP_PTR, 32'h0);
    chk("ptr_rst", 32'h0, rd);
    apb(1'b0, 12'h004, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b1, ssc_pkg::ADDR_GRP_PTR, 32'h5f);
    apb(1'b0, ssc_pkg::ADDR_GRP_PTR, 32'h0);
    chk("ptr_rd", 32'h50, rd);
    exp_ptr = 8'h50;
    $display("test registers end");
    run_op(ssc_pkg::OP_LD_PTR, 8'h00, 8'h00, 8'h7a, 8'h03);
    run_op(ssc_pkg::OP_SBC_RIR, 8'he3, 8'h16, 8'h05, 8'hff);
    run_op(ssc_pkg::OP_SBC_RR, 8'he5, 8'h00, 8'h01, 8'h7f);
    run_op(ssc_pkg::OP_SBC_FR, 8'he2, 8'h80, 8'h01, 8'h7c);
    run_op(ssc_pkg::OP_SBC_FIR, 8'h40, 8'h05, 8'h04, 8'h80);
    run_op(ssc_pkg::OP_SBC_FIM, 8'he9, 8'h7f, 8'hff, 8'h80);
    run_op(ssc_pkg::OP_SBC_IRIM, 8'ha0, 8'h10, 8'h01, 8'h00);
    $display("test subtract end");
    run_op(ssc_pkg::OP_FORCE_C, 8'h00, 8'h00, 8'h00, 8'h7c);
    run_op(ssc_pkg::OP_FORCE_C, 8'h00, 8'h00, 8'h00, 8'h80);
    run_op(ssc_pkg::OP_ASR_R, 8'he4, 8'hb8, 8'h00, 8'h0f);
    run_op(ssc_pkg::OP_ASR_IR, 8'h33, 8'h01, 8'h00, 8'hf0);
    run_op(ssc_pkg::OP_ASR_R, 8'h21, 8'h7e, 8'h00, 8'h1c);
    $display("test carry and shift end");
    // Unknown opcode, sticky bad flag, completion count and enable gate
    run_op(8'h00, 8'h00, 8'h12, 8'h34, 8'h0c);
    apb(1'b0, ssc_pkg::ADDR_STATUS, 32'h0);
    chk("status_bad", 32'h000d_0002, rd);
    apb(1'b1, ssc_pkg::ADDR_STATUS, 32'h2);
    apb(1'b0, ssc_pkg::ADDR_STATUS, 32'h0);
    chk("status_clr", 32'h000d_0000, rd);
    apb(1'b1, ssc_pkg::ADDR_CTRL, 32'h0);
    @(negedge sys_clk);
    chk("ready_off", 32'h0, {31'h0, req_ready});
    apb(1'b1, ssc_pkg::ADDR_CTRL, 32'h1);
    @(negedge sys_clk);
    chk("ready_on", 32'h1, {31'h0, req_ready});
    $display("test status and enable end");
    complete_run();
  end
endmodule
